// ==== src/rcf_pkg.sv ====
package rcf_pkg;

	localparam int DATA_W_DEF = 256;

	// Dword bookkeeping within one completion
	localparam logic [2:0] DESC_LAST = 3'h2;
	localparam logic [2:0] PAY_FIRST = 3'h3;
	localparam logic [2:0] PAY_SAT = 3'h4;

	// Straddle geometry on the 256-bit bus
	localparam logic [2:0] STRADDLE_POS = 3'h4;
	localparam logic [2:0] STRADDLE_END_MAX = 3'h3;

	// Register map, byte addresses
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_TLP_COUNT = 4'h8;
	localparam logic [3:0] REG_BEAT_COUNT = 4'hc;

	localparam int CTRL_STRADDLE_BIT = 0;
	localparam int CTRL_ALIGNED_BIT = 1;
	localparam logic [31:0] CTRL_MASK = 32'h00000003;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Sideband bus: byte enables [31:0], start [33:32], ends [41:34], abort [42]
	typedef struct packed {
		logic discontinue;
		logic [3:0] eof1;
		logic [3:0] eof0;
		logic sof1;
		logic sof0;
		logic [31:0] byte_en;
	} rcf_side_t;

	// One dword of a received completion, descriptor dwords first
	typedef struct packed {
		logic [31:0] dword;
		logic [3:0] be;
		logic first;
		logic last;
		logic discontinue;
		logic [2:0] addr_offset;
	} rcf_dword_t;

endpackage

// ==== src/rcf_completion_framer.sv ====
`timescale 1ns/1ns
module rcf_completion_framer import rcf_pkg::*; #(
	parameter int DATA_W = DATA_W_DEF
) (
	input wire logic aclk, // Clock, 10 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input rcf_dword_t src_dword, // Completion dword from the receive path
	input wire logic src_valid, // Source dword valid
	output logic src_ready, // Framer takes a dword
	output logic [DATA_W-1:0] completion_stream_data, // Stream beat data
	output logic completion_stream_valid, // Stream beat valid
	input wire logic completion_stream_ready, // User accepts the beat
	output logic [DATA_W/32-1:0] completion_dword_keep, // Per-dword keep
	output logic completion_packet_last, // Last beat of a completion, except in straddle mode
	output rcf_side_t completion_sideband_bus // Byte enables and markers
);

	localparam int N = DATA_W / 32;
	localparam logic [2:0] TOP_POS = 3'(N - 1);
	localparam logic WIDE = (N == 8);

	if (DATA_W != 64 && DATA_W != 128 && DATA_W != 256) begin : g_bad_width
		$error("DATA_W must be 64, 128 or 256");
	end

	logic [31:0] ctrl;
	logic [31:0] tlp_count;
	logic [31:0] beat_count;
	logic [2:0] pos;
	logic [2:0] idx;
	logic beat_open;
	logic strad_wait;
	logic [DATA_W-1:0] buf_data;
	logic [N-1:0] buf_keep;
	rcf_side_t buf_side;
	logic [ADDR_W-1:0] waddr;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	// Mode bits; change them only while the framer is idle
	wire aligned = ctrl[CTRL_ALIGNED_BIT];
	wire strad = ctrl[CTRL_STRADDLE_BIT] && !aligned && WIDE;

	wire accept = src_valid && src_ready;
	wire [2:0] cur_idx = src_dword.first ? 3'h0 : idx;
	wire pay0 = (cur_idx == PAY_FIRST);
	wire desc_end = (cur_idx == DESC_LAST);
	wire desc_flush = aligned && desc_end && !src_dword.last;
	wire [2:0] align_pos = src_dword.addr_offset & TOP_POS;
	wire [2:0] ppos = (aligned && pay0) ? align_pos : pos;
	// An aborted end closes the beat so nothing starts behind it
	wire end_early = strad && (ppos <= STRADDLE_END_MAX) && !src_dword.discontinue;
	wire flush_acc = accept && ((ppos == TOP_POS) || (src_dword.last && !end_early)
		|| desc_flush);
	// A half beat waiting for a straddled start is sent once the source pauses
	wire idle_flush = src_ready && !src_valid && beat_open && strad_wait;
	wire flush = flush_acc || idle_flush;
	wire start = accept && src_dword.first;
	wire fin = accept && src_dword.last;

	logic [DATA_W-1:0] nb_data;
	logic [31:0] nb_be;
	logic [N-1:0] keep_upto;

	for (genvar i = 0; i < N; i++) begin : g_lane
		wire hit = accept && (ppos == 3'(i));
		// Descriptor dwords pass through untouched
		assign nb_data[32*i +: 32] = hit ? src_dword.dword : buf_data[32*i +: 32];
		assign nb_be[4*i +: 4] = hit ? src_dword.be : buf_side.byte_en[4*i +: 4];
		assign keep_upto[i] = accept && (3'(i) <= ppos);
	end
	if (N < 8) begin : g_be_pad
		assign nb_be[31:4*N] = '0;
	end

	// Lanes skipped ahead of the payload stay kept so keep has no holes
	wire [N-1:0] nb_keep = (strad || (accept && desc_flush)) ? {N{1'b1}}
		: (buf_keep | keep_upto);

	wire second_start = start && buf_side.sof0;
	wire second_end = fin && buf_side.eof0[0];
	wire pay_abort = fin && src_dword.discontinue && (cur_idx >= PAY_FIRST);

	rcf_side_t nb_side;
	assign nb_side = '{
		discontinue: buf_side.discontinue | pay_abort,
		eof1: second_end ? {ppos, 1'b1} : buf_side.eof1,
		eof0: (fin && !buf_side.eof0[0]) ? {ppos, 1'b1} : buf_side.eof0,
		sof1: buf_side.sof1 | second_start,
		sof0: buf_side.sof0 | start,
		byte_en: nb_be
	};

	wire [2:0] next_pos = src_dword.last ? STRADDLE_POS : 3'(ppos + 3'h1);
	wire [2:0] next_idx = (cur_idx == PAY_SAT) ? PAY_SAT : 3'(cur_idx + 3'h1);
	wire next_out_valid = flush || (completion_stream_valid && !completion_stream_ready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos <= 3'h0;
			idx <= 3'h0;
			beat_open <= 1'b0;
			strad_wait <= 1'b0;
			buf_data <= '0;
			buf_keep <= '0;
			buf_side <= '0;
		end else if (flush) begin
			pos <= 3'h0;
			beat_open <= 1'b0;
			strad_wait <= 1'b0;
			buf_data <= '0;
			buf_keep <= '0;
			buf_side <= '0;
			if (accept) begin
				idx <= next_idx;
			end
		end else if (accept) begin
			pos <= next_pos;
			idx <= next_idx;
			beat_open <= 1'b1;
			strad_wait <= src_dword.last;
			buf_data <= nb_data;
			buf_keep <= nb_keep;
			buf_side <= nb_side;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			completion_stream_valid <= 1'b0;
			completion_stream_data <= '0;
			completion_dword_keep <= '0;
			completion_packet_last <= 1'b0;
			completion_sideband_bus <= '0;
		end else if (flush) begin
			completion_stream_valid <= 1'b1;
			completion_stream_data <= nb_data;
			completion_dword_keep <= nb_keep;
			completion_packet_last <= fin && !strad;
			completion_sideband_bus <= nb_side;
		end else if (completion_stream_ready) begin
			completion_stream_valid <= 1'b0;
		end
	end

	// Source is only taken into an empty output stage, trading rate for a
	// registered ready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_ready <= 1'b0;
		end else begin
			src_ready <= !next_out_valid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tlp_count <= 32'h0;
			beat_count <= 32'h0;
		end else begin
			if (start) begin
				tlp_count <= tlp_count + 32'h1;
			end
			if (completion_stream_valid && completion_stream_ready) begin
				beat_count <= beat_count + 32'h1;
			end
		end
	end

	wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire waddr_ok = (waddr == REG_CTRL) || (waddr == REG_STATUS)
		|| (waddr == REG_TLP_COUNT) || (waddr == REG_BEAT_COUNT);
	wire raddr_ok = (s_axi_araddr == REG_CTRL) || (s_axi_araddr == REG_STATUS)
		|| (s_axi_araddr == REG_TLP_COUNT) || (s_axi_araddr == REG_BEAT_COUNT);
	wire [31:0] status = {29'h0, strad_wait, beat_open, completion_stream_valid};
	wire [31:0] rd_mux = (s_axi_araddr == REG_CTRL) ? ctrl
		: (s_axi_araddr == REG_STATUS) ? status
		: (s_axi_araddr == REG_TLP_COUNT) ? tlp_count
		: (s_axi_araddr == REG_BEAT_COUNT) ? beat_count
		: 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			waddr <= '0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				waddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= waddr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RESET;
		end else if (do_write && (waddr == REG_CTRL) && wstrb_q[0]) begin
			ctrl <= wdata_q & CTRL_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= raddr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// ==== test/rcf_chk.sv ====
`timescale 1ns/1ns
module rcf_chk import rcf_pkg::*; #(
	parameter int DATA_W = DATA_W_DEF
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic [DATA_W-1:0] completion_stream_data, // Beat data
	input wire logic completion_stream_valid, // Beat valid
	input wire logic completion_stream_ready, // User ready
	input wire logic [DATA_W/32-1:0] completion_dword_keep, // Keep
	input wire logic completion_packet_last, // Last beat
	input rcf_side_t completion_sideband_bus // Markers
);
	localparam int NK = DATA_W / 32;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire v = completion_stream_valid;
	wire [DATA_W/32-1:0] k = completion_dword_keep;
	rcf_side_t sb;
	logic [DATA_W/32-1:0] k_end;
	assign sb = completion_sideband_bus;
	// Keep expected on a final beat, from the end offset
	assign k_end = NK'((32'h2 << sb.eof0[3:1]) - 32'h1);
	property p_hold;
		v && !completion_stream_ready |=> v && $stable(completion_stream_data) && $stable(sb);
	endproperty
	a_hold: assert property (p_hold) else $error("beat changed while stalled");
	property p_gap;
		v && completion_stream_ready |=> !v;
	endproperty
	a_gap: assert property (p_gap) else $error("beat repeated after accept");
	property p_keep;
		v |-> ((k + 1'b1) & k) == '0;
	endproperty
	a_keep: assert property (p_keep) else $error("keep not contiguous");
	property p_end;
		v && completion_packet_last |-> sb.eof0[0] && k == k_end;
	endproperty
	a_end: assert property (p_end) else $error("last beat keep or end mark wrong");
	property p_strad;
		v && sb.sof1 |-> !completion_packet_last && &k;
	endproperty
	a_strad: assert property (p_strad) else $error("straddled beat keep or last");
	property p_sof1;
		v && sb.sof1 |-> sb.sof0 && sb.eof0[0] && sb.eof0[3:1] <= 3'h3;
	endproperty
	a_sof1: assert property (p_sof1) else $error("second start without first");
	property p_eof1;
		v && sb.eof1[0] |-> sb.eof0[0] && sb.eof0[3:1] <= 3'h3;
	endproperty
	a_eof1: assert property (p_eof1) else $error("second end without first");
	property p_eof1_off;
		v && sb.eof1[0] |-> sb.eof1[3:2] == 2'h3;
	endproperty
	a_eof1_off: assert property (p_eof1_off) else $error("second end offset");
	property p_abort;
		v && sb.discontinue |-> !sb.sof1;
	endproperty
	a_abort: assert property (p_abort) else $error("second start with abort");
endmodule
bind rcf_completion_framer rcf_chk #(.DATA_W(DATA_W)) i_rcf_chk (.aclk(aclk),
	.aresetn(aresetn), .completion_stream_data(completion_stream_data),
	.completion_stream_valid(completion_stream_valid),
	.completion_stream_ready(completion_stream_ready),
	.completion_dword_keep(completion_dword_keep),
	.completion_packet_last(completion_packet_last),
	.completion_sideband_bus(completion_sideband_bus));

// ==== test/rcf_user_sink.sv ====
`timescale 1ns/1ns
module rcf_user_sink (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	output logic ready // Takes a beat
);
	initial ready = 1'b0;
	// Random stalls so held beats get exercised
	always @(posedge aclk) begin
		ready <= aresetn && ($urandom % 4 != 0);
	end
endmodule

// ==== test/rcf_completion_framer_tb.sv ====
`timescale 1ns/1ns
module rcf_completion_framer_tb import rcf_pkg::*;;
	typedef struct packed {
		logic [255:0] d;
		logic [7:0] m;
		logic [7:0] k;
		logic l;
		logic [10:0] s;
	} rcf_exp_t;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, src_valid;
	logic awready, wready, bvalid, arready, rvalid, src_ready, valid, ready, last;
	logic [3:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [255:0] data, md;
	logic [31:0] ebe;
	logic [7:0] keep;
	rcf_dword_t sd;
	rcf_side_t sb;
	rcf_exp_t e;
	rcf_exp_t q[$];
	logic [31:0] sent[$];
	int sp, err_total, check_count;
	rcf_completion_framer i_rcf_completion_framer (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.src_dword(sd), .src_valid(src_valid), .src_ready(src_ready),
		.completion_stream_data(data), .completion_stream_valid(valid),
		.completion_stream_ready(ready), .completion_dword_keep(keep),
		.completion_packet_last(last), .completion_sideband_bus(sb));
	rcf_user_sink i_rcf_user_sink (.aclk(aclk), .aresetn(aresetn), .ready(ready));
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task print_verdict;
		if (err_total == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task cmp(input logic [299:0] g, input logic [299:0] x);
		check_count++;
		if (g !== x) begin
			err_total++;
			$display("mismatch %0t got %h exp %h", $time, g, x);
		end
	endtask
	task acc(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= w;
		wvalid <= w;
		arvalid <= !w;
		bready <= w;
		rready <= !w;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
		end while (!(w ? bvalid : rvalid));
		bready <= 1'b0;
		rready <= 1'b0;
		if (w) cmp(bresp, er);
		else cmp({rdata, rresp}, {d, er});
	endtask
	task gen(input int n);
		repeat (n) sent.push_back($urandom);
	endtask
	function automatic logic [255:0] pk(input int f, input int n, input int lane);
		pk = '0;
		for (int i = 0; i < n; i++) pk[(lane + i) * 32 +: 32] = sent[f + i];
	endfunction
	task ex(input logic [255:0] d, input logic [7:0] m, k, input logic l, input logic [10:0] s);
		q.push_back('{d, m, k, l, s});
	endtask
	// Source stays valid across calls so completions arrive back to back
	task send(input int n, input logic [2:0] off, input logic disc);
		for (int i = 0; i < n; i++) begin
			sd <= '{sent[sp], 4'hf, i == 0, i == n - 1, disc, off};
			sp++;
			src_valid <= 1'b1;
			do @(posedge aclk); while (!src_ready);
		end
	endtask
	task idle;
		src_valid <= 1'b0;
		repeat (300) if (q.size() != 0) @(posedge aclk);
		repeat (2) @(posedge aclk);
	endtask
	always @(posedge aclk) begin
		if (aresetn && valid && ready) begin
			e = q.size() ? q.pop_front() : '1;
			md = data;
			for (int j = 0; j < 8; j++) if (!e.m[j]) md[j * 32 +: 32] = 32'h0;
			// Every dword sent carries full enables; unused lanes carry none
			for (int j = 0; j < 8; j++) ebe[j * 4 +: 4] = {4{e.m[j]}};
			cmp(md, e.d);
			cmp(sb.byte_en, ebe);
			cmp(keep, e.k);
			cmp({last, sb[42:32]}, {e.l, e.s});
		end
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, src_valid} = '0;
		{awaddr, araddr, wdata, sd} = '0;
		void'($urandom(32'h48ad4b01));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		acc(0, REG_CTRL, CTRL_RESET, RESP_OKAY);
		acc(0, 4'h2, 32'h0, RESP_SLVERR);
		acc(1, 4'h6, 32'h0, RESP_SLVERR);
		gen(14);
		ex(pk(0, 4, 0), 8'h0f, 8'h0f, 1, 11'h01d);
		ex(pk(4, 8, 0), 8'hff, 8'hff, 0, 11'h001);
		ex(pk(12, 2, 0), 8'h03, 8'h03, 1, 11'h00c);
		send(4, 0, 0);
		send(10, 0, 0);
		idle;
		acc(1, REG_CTRL, 32'h2, RESP_OKAY);
		gen(5);
		ex(pk(14, 3, 0), 8'h07, 8'hff, 0, 11'h001);
		ex(pk(17, 2, 5), 8'h60, 8'h7f, 1, 11'h034);
		send(5, 3'h5, 0);
		idle;
		acc(1, REG_CTRL, 32'h1, RESP_OKAY);
		gen(16);
		ex(pk(19, 4, 0) | pk(23, 4, 4), 8'hff, 8'hff, 0, 11'h3df);
		ex(pk(27, 4, 0), 8'h0f, 8'hff, 0, 11'h41d);
		ex(pk(31, 4, 0), 8'h0f, 8'hff, 0, 11'h01d);
		send(4, 0, 0);
		send(4, 0, 0);
		send(4, 0, 1);
		send(4, 0, 0);
		idle;
		acc(0, REG_TLP_COUNT, 32'h7, RESP_OKAY);
		acc(0, REG_BEAT_COUNT, 32'h8, RESP_OKAY);
		cmp(q.size(), 0);
		print_verdict;
	end
	initial begin
		#2000000;
		err_total++;
		print_verdict;
	end
endmodule
